//--- pkg/sep_pkg.sv
// Constants, types and helpers shared by the serial EEPROM pin control block
// What this block does
// - Chip select low selects the device; high deselects it into standby.
// - A started or running programming cycle always finishes despite deselection.
// - Chip select rising mid-write keeps the device active until write ends.
// - Deselection at once releases the serial output to high impedance.
// - Chip select rising after a complete valid write sequence starts the write.
// - After power-up nothing is accepted until chip select has been low.
// - Serial input bits are captured on each serial clock rising edge.
// - Serial output changes only after a serial clock falling edge.
// - Write protect low blocks array and status writes and keeps the write enable latch clear; reads work.
// - Write protect falling clears the write enable latch and blocks programming.
// - A write already running when write protect falls completes unaffected.
// - Pause input low mid-sequence suspends transfer, keeping sequence state.
// - Pause lowered with clock high takes effect at the next clock fall.
// - While paused, output floats and clock and input changes are ignored.
// - Resume only when the pause input rises while the clock is low.
// - Pause input low always floats the serial output immediately.
// - Each self-timed write cycle ends within 5 ms of its start.
// - All fields shift most significant bit first in both directions.
// - An internal write happens only with the write enable latch set.
// - The write enable latch clears when an internal write finishes.
// - Write in progress reads 1 during an internal write, else 0.
package sep_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_FREQ_KHZ = 125000;
  localparam int WRITE_CYCLE_MS = 5;
  // Longest time, so rounded down; exact at this rate
  localparam int WRITE_CYCLES = WRITE_CYCLE_MS * CLK_FREQ_KHZ;
  localparam int WTIMER_W = 20;

  // ----------------------------------------
  // Pin synchroniser layout and reset values
  // ----------------------------------------
  localparam int PIN_N = 5;
  localparam int PIN_CS = 4;
  localparam int PIN_SCK = 3;
  localparam int PIN_SI = 2;
  localparam int PIN_HOLD = 1;
  localparam int PIN_WP = 0;
  // Select high, clock low, data low, pause high, protect high
  localparam logic [PIN_N-1:0] PIN_RST = 5'h13;

  // ----------------------------------------
  // Serial counters
  // ----------------------------------------
  localparam int BYTE_W = 8;
  localparam logic [2:0] BIT_CNT_RST = 3'h0;
  localparam logic [2:0] BIT_CNT_LAST = 3'h7;
  localparam logic [7:0] BYTE_CNT_RST = 8'h00;
  localparam logic [7:0] BYTE_CNT_MAX = 8'hFF;
  localparam logic [7:0] BYTE_RST = 8'h00;

  // ----------------------------------------
  // Pause state machine
  // ----------------------------------------
  typedef enum logic [1:0] {
    SEP_LINK_RUN = 2'b00,
    SEP_LINK_WAIT = 2'b01,
    SEP_LINK_HOLD = 2'b10
  } sep_link_t;

  // Edge detect between two registered samples
  function automatic logic sep_rise(input logic prev, input logic cur);
    return ~prev & cur;
  endfunction : sep_rise

endpackage : sep_pkg

//--- pkg/sep_pins_if.sv
// Synchronised pin levels and edges passed from the synchroniser to the control logic
interface sep_pins_if;
  logic cs_n;
  logic sck;
  logic si;
  logic hold_n;
  logic wp_n;
  logic sck_rise;
  logic sck_fall;
  logic cs_rise;
  logic hold_fall;
  logic hold_rise;

  modport src (
    output cs_n, sck, si, hold_n, wp_n, sck_rise, sck_fall, cs_rise, hold_fall, hold_rise
  );
  modport dst (
    input cs_n, sck, si, hold_n, wp_n, sck_rise, sck_fall, cs_rise, hold_fall, hold_rise
  );
endinterface : sep_pins_if

//--- rtl/sep_pin_sync.sv
// Two-stage synchroniser and edge detector for the serial link pins
module sep_pin_sync
  import sep_pkg::*;
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // Raw pins
  input wire logic [PIN_N-1:0] pins_in,
  // Synchronised view
  sep_pins_if.src syn_out
);

  logic [PIN_N-1:0] meta_r;
  logic [PIN_N-1:0] meta_nxt;
  logic [PIN_N-1:0] sync_r;
  logic [PIN_N-1:0] sync_nxt;
  logic [PIN_N-1:0] last_r;
  logic [PIN_N-1:0] last_nxt;

  // ----------------------------------------
  // Stages: meta is read only by sync
  // ----------------------------------------
  always_comb begin
    meta_nxt = pins_in;
    sync_nxt = meta_r;
    last_nxt = sync_r;
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      meta_r <= PIN_RST;
      sync_r <= PIN_RST;
      last_r <= PIN_RST;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
      last_r <= last_nxt;
    end
  end

  // Levels and edges, all from the second stage onward
  assign syn_out.cs_n = sync_r[PIN_CS];
  assign syn_out.sck = sync_r[PIN_SCK];
  assign syn_out.si = sync_r[PIN_SI];
  assign syn_out.hold_n = sync_r[PIN_HOLD];
  assign syn_out.wp_n = sync_r[PIN_WP];
  assign syn_out.sck_rise = sep_rise(last_r[PIN_SCK], sync_r[PIN_SCK]);
  assign syn_out.sck_fall = sep_rise(sync_r[PIN_SCK], last_r[PIN_SCK]);
  assign syn_out.cs_rise = sep_rise(last_r[PIN_CS], sync_r[PIN_CS]);
  assign syn_out.hold_rise = sep_rise(last_r[PIN_HOLD], sync_r[PIN_HOLD]);
  assign syn_out.hold_fall = sep_rise(sync_r[PIN_HOLD], last_r[PIN_HOLD]);

endmodule : sep_pin_sync

//--- rtl/sep_write_timer.sv
// Self-timed nonvolatile write cycle timer
module sep_write_timer
  import sep_pkg::*;
#(
  parameter int CYCLES = WRITE_CYCLES
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // Control
  input wire logic start_in,
  output logic busy_out,
  output logic done_out
);

  logic [WTIMER_W-1:0] cnt_r;
  logic [WTIMER_W-1:0] cnt_nxt;
  logic busy_r;
  logic busy_nxt;
  logic done_r;
  logic done_nxt;

  // ----------------------------------------
  // Countdown; nothing but the count ends it
  // ----------------------------------------
  always_comb begin
    cnt_nxt = cnt_r;
    busy_nxt = busy_r;
    done_nxt = 1'b0;
    if (busy_r) begin
      if (cnt_r == WTIMER_W'(1)) begin
        busy_nxt = 1'b0; // Ends after exactly CYCLES clocks
        done_nxt = 1'b1;
      end
      cnt_nxt = cnt_r - WTIMER_W'(1);
    end else if (start_in) begin
      busy_nxt = 1'b1;
      cnt_nxt = WTIMER_W'(CYCLES);
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      cnt_r <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
    end
  end

  assign busy_out = busy_r;
  assign done_out = done_r;

endmodule : sep_write_timer

//--- rtl/sep_pin_ctrl.sv
// Serial EEPROM slave pin control: select, shift edges, write protect, pause
module sep_pin_ctrl
  import sep_pkg::*;
#(
  parameter int WRITE_CYCLES_P = WRITE_CYCLES
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // Serial pins
  input wire logic spi_cs_n_in,
  input wire logic spi_sck_in,
  input wire logic spi_si_in,
  input wire logic spi_hold_n_in,
  input wire logic spi_wp_n_in,
  output logic spi_so_out,
  output logic spi_so_oe_out,
  // Received bytes to the command decoder
  output logic [7:0] rx_byte_out,
  output logic rx_byte_valid_out,
  output logic [7:0] rx_byte_index_out,
  // Bytes to send
  input wire logic [7:0] tx_byte_in,
  input wire logic tx_enable_in,
  output logic tx_byte_taken_out,
  // Write control from the command decoder
  input wire logic wren_seq_in,
  input wire logic wrdi_in,
  input wire logic write_seq_valid_in,
  output logic write_start_out,
  // Status
  output logic write_in_progress_out,
  output logic write_enable_latch_out,
  output logic selected_out,
  output logic standby_out,
  output logic paused_out
);

  sep_pins_if syn ();

  // ----------------------------------------
  // Pin synchroniser and write timer
  // ----------------------------------------
  sep_pin_sync u_sync (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .pins_in({spi_cs_n_in, spi_sck_in, spi_si_in, spi_hold_n_in, spi_wp_n_in}),
    .syn_out(syn)
  );

  logic wstart;
  logic wbusy;
  logic wdone;

  sep_write_timer #(
    .CYCLES(WRITE_CYCLES_P)
  ) u_timer (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .start_in(wstart),
    .busy_out(wbusy),
    .done_out(wdone)
  );

  // ----------------------------------------
  // Selection state
  // ----------------------------------------
  logic armed_r;
  logic armed_nxt;
  logic started_r;
  logic started_nxt;
  logic sel;
  logic go;

  // Selected only once a low select has been seen after reset
  assign sel = armed_r & ~syn.cs_n;

  // ----------------------------------------
  // Pause state machine
  // ----------------------------------------
  sep_link_t link_r;
  sep_link_t link_nxt;

  always_comb begin
    link_nxt = link_r;
    if (!sel) begin
      link_nxt = SEP_LINK_RUN; // Deselect ends any pause
    end else begin
      unique case (link_r)
        SEP_LINK_RUN: begin
          if (syn.hold_fall && started_r) begin
            if (!syn.sck) begin
              link_nxt = SEP_LINK_HOLD;
            end else if (syn.sck_fall) begin
              link_nxt = SEP_LINK_HOLD;
            end else begin
              link_nxt = SEP_LINK_WAIT; // Clock high: wait for its fall
            end
          end
        end
        SEP_LINK_WAIT: begin
          if (syn.hold_n) begin
            link_nxt = SEP_LINK_RUN;
          end else if (syn.sck_fall) begin
            link_nxt = SEP_LINK_HOLD;
          end
        end
        SEP_LINK_HOLD: begin
          // A release with the clock high is not a resume
          if (syn.hold_rise && !syn.sck) begin
            link_nxt = SEP_LINK_RUN;
          end
        end
        default: begin
          link_nxt = SEP_LINK_RUN;
        end
      endcase
    end
  end

  // Edges count only when selected and not entering or in a pause
  assign go = sel & (link_nxt != SEP_LINK_HOLD) & (link_r != SEP_LINK_HOLD);

  // ----------------------------------------
  // Receive shifter and counters
  // ----------------------------------------
  logic [2:0] bit_cnt_r;
  logic [2:0] bit_cnt_nxt;
  logic [7:0] byte_cnt_r;
  logic [7:0] byte_cnt_nxt;
  logic [6:0] rx_sh_r;
  logic [6:0] rx_sh_nxt;
  logic [7:0] rx_byte_r;
  logic [7:0] rx_byte_nxt;
  logic [7:0] rx_idx_r;
  logic [7:0] rx_idx_nxt;
  logic rx_vld_r;
  logic rx_vld_nxt;

  always_comb begin
    bit_cnt_nxt = bit_cnt_r;
    byte_cnt_nxt = byte_cnt_r;
    rx_sh_nxt = rx_sh_r;
    rx_byte_nxt = rx_byte_r;
    rx_idx_nxt = rx_idx_r;
    rx_vld_nxt = 1'b0;
    started_nxt = started_r;
    armed_nxt = armed_r | ~syn.cs_n;
    if (syn.cs_n) begin
      bit_cnt_nxt = BIT_CNT_RST; // Fresh instruction byte each selection
      byte_cnt_nxt = BYTE_CNT_RST;
      started_nxt = 1'b0;
    end else if (go && syn.sck_rise) begin
      // Sample on the rising edge, first bit is the MSB
      rx_sh_nxt = {rx_sh_r[5:0], syn.si};
      bit_cnt_nxt = bit_cnt_r + 3'h1;
      started_nxt = 1'b1;
      if (bit_cnt_r == BIT_CNT_LAST) begin
        rx_byte_nxt = {rx_sh_r, syn.si};
        rx_idx_nxt = byte_cnt_r;
        rx_vld_nxt = 1'b1;
        // Saturates so long reads never wrap the index
        if (byte_cnt_r != BYTE_CNT_MAX) begin
          byte_cnt_nxt = byte_cnt_r + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      bit_cnt_r <= BIT_CNT_RST;
      byte_cnt_r <= BYTE_CNT_RST;
      rx_sh_r <= '0;
      rx_byte_r <= BYTE_RST;
      rx_idx_r <= BYTE_CNT_RST;
      rx_vld_r <= 1'b0;
      started_r <= 1'b0;
      armed_r <= 1'b0;
      link_r <= SEP_LINK_RUN;
    end else begin
      bit_cnt_r <= bit_cnt_nxt;
      byte_cnt_r <= byte_cnt_nxt;
      rx_sh_r <= rx_sh_nxt;
      rx_byte_r <= rx_byte_nxt;
      rx_idx_r <= rx_idx_nxt;
      rx_vld_r <= rx_vld_nxt;
      started_r <= started_nxt;
      armed_r <= armed_nxt;
      link_r <= link_nxt;
    end
  end

  // ----------------------------------------
  // Transmit shifter and output enable
  // ----------------------------------------
  logic [6:0] tx_sh_r;
  logic [6:0] tx_sh_nxt;
  logic so_r;
  logic so_nxt;
  logic tx_act_r;
  logic tx_act_nxt;
  logic taken_r;
  logic taken_nxt;
  logic oe_r;
  logic oe_nxt;

  always_comb begin
    tx_sh_nxt = tx_sh_r;
    so_nxt = so_r;
    tx_act_nxt = tx_act_r;
    taken_nxt = 1'b0;
    if (!sel) begin
      tx_act_nxt = 1'b0;
    end else if (go && syn.sck_fall && started_r) begin
      // Output moves only after a falling edge
      if (bit_cnt_r == BIT_CNT_RST) begin
        so_nxt = tx_byte_in[7]; // MSB leads
        tx_sh_nxt = tx_byte_in[6:0];
        tx_act_nxt = tx_enable_in;
        taken_nxt = 1'b1;
      end else begin
        so_nxt = tx_sh_r[6];
        tx_sh_nxt = {tx_sh_r[5:0], 1'b0};
      end
    end
    // Float on deselect, pause or a low pause input at any clock level
    oe_nxt = sel & syn.hold_n & (link_r == SEP_LINK_RUN) & tx_act_nxt;
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      tx_sh_r <= '0;
      so_r <= 1'b0;
      tx_act_r <= 1'b0;
      taken_r <= 1'b0;
      oe_r <= 1'b0;
    end else begin
      tx_sh_r <= tx_sh_nxt;
      so_r <= so_nxt;
      tx_act_r <= tx_act_nxt;
      taken_r <= taken_nxt;
      oe_r <= oe_nxt;
    end
  end

  // ----------------------------------------
  // Write enable latch and write start
  // ----------------------------------------
  logic wel_r;
  logic wel_nxt;
  logic wstart_r;
  logic at_boundary;

  // Select rising right after a whole byte, whether or not the link is paused
  assign at_boundary = syn.cs_rise & armed_r & started_r & (bit_cnt_r == BIT_CNT_RST);

  // Needs the latch, protect high and an idle timer
  assign wstart = at_boundary & write_seq_valid_in & wel_r & syn.wp_n & ~wbusy;

  always_comb begin
    wel_nxt = wel_r;
    if (wdone || wrdi_in) begin
      wel_nxt = 1'b0; // Finished write drops the latch
    end
    // Latch is set only when select rises after the enable byte
    if (at_boundary && wren_seq_in) begin
      wel_nxt = 1'b1;
    end
    // Protect low overrides everything; the running timer is untouched
    if (!syn.wp_n) begin
      wel_nxt = 1'b0;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      wel_r <= 1'b0;
      wstart_r <= 1'b0;
    end else begin
      wel_r <= wel_nxt;
      wstart_r <= wstart;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign spi_so_out = so_r;
  assign spi_so_oe_out = oe_r;
  assign rx_byte_out = rx_byte_r;
  assign rx_byte_valid_out = rx_vld_r;
  assign rx_byte_index_out = rx_idx_r;
  assign tx_byte_taken_out = taken_r;
  assign write_start_out = wstart_r;
  // Timer runs on regardless of select
  assign write_in_progress_out = wbusy;
  assign write_enable_latch_out = wel_r;
  assign selected_out = sel;
  // Standby only once deselected and the write is over
  assign standby_out = ~sel & ~wbusy;
  assign paused_out = (link_r == SEP_LINK_HOLD);

endmodule : sep_pin_ctrl

//--- tb/sep_pin_ctrl_sva.sv
// Port checker for the serial EEPROM pin control block
module sep_pin_ctrl_sva #(
  parameter int WRITE_CYCLES_P = 200
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // Serial pins
  input wire logic spi_cs_n_in,
  input wire logic spi_sck_in,
  input wire logic spi_hold_n_in,
  input wire logic spi_wp_n_in,
  input wire logic spi_so_out,
  input wire logic spi_so_oe_out,
  // Status
  input wire logic rx_byte_valid_out,
  input wire logic write_start_out,
  input wire logic write_in_progress_out,
  input wire logic write_enable_latch_out,
  input wire logic standby_out,
  input wire logic paused_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Write length counter and properties
  // ----------------------------------------
  logic [19:0] wip_cnt_r;
  logic [19:0] wip_cnt_nxt;
  // Counted here, since the write outlasts any short repetition
  always_comb begin
    wip_cnt_nxt = write_in_progress_out ? wip_cnt_r + 20'h00001 : 20'h00000;
  end
  always_ff @(posedge clock_in) begin
    wip_cnt_r <= rst_n_in ? wip_cnt_nxt : 20'h00000;
  end
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_n_in);
  chk_desel_float: assert property ($rose(spi_cs_n_in) |-> ##[1:5] !spi_so_oe_out)
    else $error("SO enable stayed on after deselect");
  chk_hold_float: assert property (!spi_hold_n_in [*6] |-> !spi_so_oe_out)
    else $error("SO enable on with pause low");
  chk_write_len: assert property ($fell(write_in_progress_out) |-> wip_cnt_r == 20'(WRITE_CYCLES_P))
    else $error("write cycle length wrong");
  chk_start_wip: assert property (write_start_out |-> write_in_progress_out && !$past(write_in_progress_out))
    else $error("start without fresh busy flag");
  chk_start_wel: assert property (write_start_out |-> $past(write_enable_latch_out))
    else $error("write started with latch clear");
  chk_done_wel: assert property ($fell(write_in_progress_out) |-> ##[0:2] !write_enable_latch_out)
    else $error("latch kept after write");
  chk_protect_wel: assert property (!spi_wp_n_in [*5] |-> !write_enable_latch_out && !write_start_out)
    else $error("latch or start under protect");
  chk_busy_awake: assert property (write_in_progress_out |-> !standby_out)
    else $error("standby during write");
  chk_pause_quiet: assert property (paused_out |-> !rx_byte_valid_out && !spi_so_oe_out)
    else $error("activity while paused");
  chk_so_edge: assert property ($changed(spi_so_out) && spi_so_oe_out |-> !$past(spi_sck_in, 3))
    else $error("SO moved off a falling clock");
  chk_desel_idle: assert property (spi_cs_n_in [*6] |-> !rx_byte_valid_out)
    else $error("byte taken while deselected");
  cov_write: cover property (write_start_out);
  cov_pause: cover property (paused_out);
  cov_wp_write: cover property ($fell(write_in_progress_out) && !spi_wp_n_in);
endmodule : sep_pin_ctrl_sva

//--- tb/sep_spi_model.sv
// Behavioural SPI master that drives the serial EEPROM pins
module sep_spi_model (
  // Clock
  input wire logic clock_in,
  // Pins towards the device
  output logic cs_n_out,
  output logic sck_out,
  output logic si_out,
  output logic hold_n_out,
  output logic wp_n_out,
  input wire logic so_in,
  input wire logic so_oe_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Bus tasks, half an SCK period is 10 clocks
  // ----------------------------------------
  // Idle bus: deselected, clock parked low, pause and protect released
  initial begin
    cs_n_out = 1'b1;
    sck_out = 1'b0;
    si_out = 1'b0;
    hold_n_out = 1'b1;
    wp_n_out = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
  endtask : tick
  // A floating SO reads as unknown, so a missing drive never matches
  task automatic shift(input logic [7:0] d, input int n, output logic [7:0] q);
    q = 8'h00;
    for (int i = 0; i < n; i++) begin
      si_out <= d[7 - i];
      tick(10);
      sck_out <= 1'b1;
      q = {q[6:0], so_oe_in ? so_in : 1'bx};
      tick(10);
      sck_out <= 1'b0;
    end
    // Toggled before the gap so a following call never writes SI in the same step
    si_out <= ~si_out; // Stale data must not look held
    tick(10);
  endtask : shift
  task automatic sel();
    cs_n_out <= 1'b0;
    tick(10);
  endtask : sel
  task automatic desel();
    cs_n_out <= 1'b1;
    tick(30);
  endtask : desel
  // Called only with SCK parked low
  task automatic pause(input logic on);
    hold_n_out <= !on;
    tick(10);
  endtask : pause
  task automatic protect(input logic on);
    wp_n_out <= !on;
    tick(10);
  endtask : protect
endmodule : sep_spi_model

//--- tb/sep_pin_ctrl_test.sv
// Self-checking testbench for the serial EEPROM pin control block
module sep_pin_ctrl_test;
  import sep_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Harness
  // ----------------------------------------
  localparam int WRITE_CYCLES_P = 200;
  logic clock_in = 1'b0;
  logic rst_n_in;
  logic [7:0] tx_byte_in;
  logic tx_enable_in;
  logic wren_seq_in;
  logic wrdi_in;
  logic write_seq_valid_in;
  logic spi_cs_n_in, spi_sck_in, spi_si_in, spi_hold_n_in, spi_wp_n_in;
  logic [7:0] rx_byte_out, rx_byte_index_out, rx_last, idx_last, q;
  logic spi_so_out, spi_so_oe_out, rx_byte_valid_out, tx_byte_taken_out, write_start_out;
  logic write_in_progress_out, write_enable_latch_out, selected_out, standby_out, paused_out;
  int fail_count = 0;
  int n_tests = 0;
  int rx_n = 0;
  int tk_n = 0;
  always #4 clock_in = ~clock_in;
  sep_pin_ctrl #(.WRITE_CYCLES_P(WRITE_CYCLES_P)) dut (
    .clock_in, .rst_n_in, .spi_cs_n_in, .spi_sck_in, .spi_si_in, .spi_hold_n_in,
    .spi_wp_n_in, .spi_so_out, .spi_so_oe_out, .rx_byte_out, .rx_byte_valid_out,
    .rx_byte_index_out, .tx_byte_in, .tx_enable_in, .tx_byte_taken_out, .wren_seq_in,
    .wrdi_in, .write_seq_valid_in, .write_start_out, .write_in_progress_out,
    .write_enable_latch_out, .selected_out, .standby_out, .paused_out
  );
  sep_spi_model u_master (
    .clock_in, .cs_n_out(spi_cs_n_in), .sck_out(spi_sck_in), .si_out(spi_si_in),
    .hold_n_out(spi_hold_n_in), .wp_n_out(spi_wp_n_in), .so_in(spi_so_out),
    .so_oe_in(spi_so_oe_out)
  );
  // Latch every received byte and count loaded bytes so tasks can judge them later
  always @(posedge clock_in) begin
    if (rx_byte_valid_out === 1'b1) begin
      rx_last <= rx_byte_out;
      idx_last <= rx_byte_index_out;
      rx_n <= rx_n + 1;
    end
    if (tx_byte_taken_out === 1'b1) begin
      tk_n <= tk_n + 1;
    end
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic finish_test();
    if (fail_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Clocking while deselected must not count, before and after arming
  task automatic t_idle();
    int n0;
    n0 = rx_n;
    u_master.shift(8'hFF, 8, q);
    chk("bytes while idle", 8'h00, 8'(rx_n - n0));
  endtask : t_idle
  task automatic t_read();
    int k0;
    k0 = tk_n;
    tx_byte_in <= 8'h3C;
    tx_enable_in <= 1'b1;
    u_master.sel();
    chk("selected", 8'h01, {7'h00, selected_out});
    u_master.shift(8'hA5, 8, q);
    chk("rx byte", 8'hA5, rx_last);
    chk("rx index", 8'h00, idx_last);
    u_master.shift(8'h0F, 8, q);
    chk("so byte", 8'h3C, q);
    chk("rx index", 8'h01, idx_last);
    chk("bytes loaded", 8'h02, 8'(tk_n - k0));
    u_master.desel();
    tx_enable_in <= 1'b0;
    chk("so enable", 8'h00, {7'h00, spi_so_oe_out});
    chk("selected", 8'h00, {7'h00, selected_out});
    chk("standby", 8'h01, {7'h00, standby_out});
  endtask : t_read
  // Enable command closed after the given number of bits
  task automatic wren(input int bits);
    wren_seq_in <= 1'b1;
    u_master.sel();
    u_master.shift(8'h06, bits, q);
    u_master.desel();
    wren_seq_in <= 1'b0;
    u_master.tick(1);
  endtask : wren
  // Write command and one more byte, closed on a byte boundary
  task automatic wr();
    write_seq_valid_in <= 1'b1;
    u_master.sel();
    u_master.shift(8'h02, 8, q);
    u_master.shift(8'h5A, 8, q);
    u_master.desel();
    write_seq_valid_in <= 1'b0;
    u_master.tick(1);
  endtask : wr
  // Bounded wait for the write timer, then two settling cycles
  task automatic wait_write();
    for (int n = 0; n < 300 && write_in_progress_out === 1'b1; n++) begin
      u_master.tick(1);
    end
    u_master.tick(2);
  endtask : wait_write
  task automatic t_write();
    wren(4);
    chk("latch after partial", 8'h00, {7'h00, write_enable_latch_out});
    wren(8);
    chk("latch set", 8'h01, {7'h00, write_enable_latch_out});
    wr();
    chk("write running", 8'h01, {7'h00, write_in_progress_out});
    chk("standby in write", 8'h00, {7'h00, standby_out});
    wait_write();
    chk("write ended", 8'h00, {7'h00, write_in_progress_out});
    chk("latch after write", 8'h00, {7'h00, write_enable_latch_out});
    chk("standby after write", 8'h01, {7'h00, standby_out});
    // Protect falls in mid-write: the latch drops, the write runs on
    wren(8);
    wr();
    u_master.protect(1'b1);
    chk("latch on protect", 8'h00, {7'h00, write_enable_latch_out});
    chk("write after protect", 8'h01, {7'h00, write_in_progress_out});
    wait_write();
    chk("protected write ended", 8'h00, {7'h00, write_in_progress_out});
    wren(8);
    wr();
    chk("write under protect", 8'h00, {7'h00, write_in_progress_out});
    u_master.protect(1'b0);
    // Latch cleared by the decoder: a later write must not start
    wren(8);
    wrdi_in <= 1'b1;
    u_master.tick(1);
    wrdi_in <= 1'b0;
    u_master.tick(2);
    chk("latch after clear", 8'h00, {7'h00, write_enable_latch_out});
    wr();
    chk("write without latch", 8'h00, {7'h00, write_in_progress_out});
  endtask : t_write
  // Pause in mid-byte while sending, clock pulses meanwhile, then finish the byte
  task automatic t_hold();
    tx_byte_in <= 8'h96;
    tx_enable_in <= 1'b1;
    u_master.sel();
    u_master.shift(8'hC3, 8, q);
    u_master.shift(8'hA0, 4, q);
    chk("so before pause", 8'h09, q);
    u_master.pause(1'b1);
    chk("paused", 8'h01, {7'h00, paused_out});
    chk("so enable paused", 8'h00, {7'h00, spi_so_oe_out});
    u_master.shift(8'hFF, 3, q);
    u_master.pause(1'b0);
    chk("resumed", 8'h00, {7'h00, paused_out});
    u_master.shift(8'h50, 4, q);
    chk("so across pause", 8'h06, q);
    chk("byte across pause", 8'hA5, rx_last);
    chk("index across pause", 8'h01, idx_last);
    u_master.desel();
    tx_enable_in <= 1'b0;
  endtask : t_hold
  // Main sequence after a six-cycle reset
  initial begin
    rst_n_in <= 1'b0;
    tx_byte_in <= 8'h00;
    tx_enable_in <= 1'b0;
    wren_seq_in <= 1'b0;
    wrdi_in <= 1'b0;
    write_seq_valid_in <= 1'b0;
    repeat (6) @(posedge clock_in);
    rst_n_in <= 1'b1;
    u_master.tick(2);
    t_idle();
    t_read();
    t_idle();
    t_write();
    t_hold();
    finish_test();
  end
  // Watchdog, a few times the expected run length
  initial begin
    repeat (20000) @(posedge clock_in);
    fail_count++;
    finish_test();
  end
endmodule : sep_pin_ctrl_test

bind sep_pin_ctrl sep_pin_ctrl_sva #(.WRITE_CYCLES_P(WRITE_CYCLES_P)) u_sva (
  .clock_in, .rst_n_in, .spi_cs_n_in, .spi_sck_in, .spi_hold_n_in, .spi_wp_n_in,
  .spi_so_out, .spi_so_oe_out, .rx_byte_valid_out, .write_start_out,
  .write_in_progress_out, .write_enable_latch_out, .standby_out, .paused_out
);
